// *** rps_pkg.sv ***
// Package for the register page stack: offsets, reset values, lookup and bus types.
// Assumes an 8-bit special-function register access path from the processor core.
package rps_pkg;

  localparam int unsigned PAGE_W = 8;

  // Register offsets in the special-function register space.
  localparam logic [7:0] OFS_CONTROL = 8'h84;
  localparam logic [7:0] OFS_SECOND  = 8'h85;
  localparam logic [7:0] OFS_ACTIVE  = 8'ha7;
  localparam logic [7:0] OFS_THIRD   = 8'ha6;

  // Field positions and reset values.
  localparam int unsigned CTL_EN_BIT    = 0;
  localparam logic [7:0]  RST_ACTIVE    = 8'h00;
  localparam logic [7:0]  RST_SECOND    = 8'h00;
  localparam logic [7:0]  RST_THIRD     = 8'h00;
  localparam logic        RST_AUTO_EN   = 1'b1;

  // Interrupt source index width and the default page loaded on entry.
  localparam int unsigned SRC_W        = 5;
  localparam logic [7:0]  PAGE_DEFAULT = 8'h00;
  localparam logic [7:0]  PAGE_ALT_A   = 8'h0c;
  localparam logic [7:0]  PAGE_ALT_B   = 8'h10;

  // Register access from the core.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rps_acc_t;

  // Interrupt sequencer events.
  typedef struct packed {
    logic             vector;
    logic [SRC_W-1:0] src;
    logic             ret;
  } rps_irq_t;

endpackage

// *** rps_page_stack.sv ***
// Three-entry page stack selecting the active special-function register page.
// Assumes the core presents register accesses and interrupt vector/return events as
// one-cycle strobes on i_core_clk.
`timescale 1ns/1ps

// Contract
// - Active page selects every register access page
// - Write to active page replaces it immediately
// - Reading active page returns page in use
// - Auto paging loads interrupting peripheral page
// - Interrupt return pops previous page back
// - Return restores whatever stack currently holds
// - Register access never pushes or pops
// - Return copies second entry into active
// - Writing second entry sets that entry
// - Reading second entry returns its value
// - Stack is exactly three bytes deep
// - Entry writes change only that entry
// - Entry pushes active to second, second to third
// - Return moves third into second simultaneously
// - Control bit 0 enables paging, resets one
module rps_page_stack #(
  parameter int unsigned DEPTH = 3                         // Stack entries.
) (
  input  wire logic               i_core_clk,              // Core clock.
  input  wire logic               i_rst_n,                 // Synchronous reset, active low.
  input  wire rps_pkg::rps_acc_t  i_acc,                   // Register access strobe and data.
  input  wire rps_pkg::rps_irq_t  i_irq,                   // Interrupt vector and return events.
  output logic [7:0]              o_rdata,                 // Read data for the addressed register.
  output logic                    o_hit,                   // Address is one of this block's registers.
  output logic [7:0]              o_page                   // Page used for every register access.
);

  // Entry 0 is the active page; higher entries hold the pages of interrupted contexts.
  logic [7:0] stack [DEPTH];
  logic [7:0] next_stack [DEPTH];
  logic [7:0] push_stack [DEPTH];
  logic [7:0] pop_stack [DEPTH];
  logic [7:0] event_stack [DEPTH];
  logic [7:0] rst_stack [DEPTH];
  logic       auto_en;
  logic       next_auto_en;

  // Address decode of the four registers held here.
  wire sel_ctl    = (i_acc.addr == rps_pkg::OFS_CONTROL);
  wire sel_active = (i_acc.addr == rps_pkg::OFS_ACTIVE);
  wire sel_second = (i_acc.addr == rps_pkg::OFS_SECOND);
  wire sel_third  = (i_acc.addr == rps_pkg::OFS_THIRD);
  wire sel_any    = sel_ctl || sel_active || sel_second || sel_third;

  // Write strobes; a read has no side effect, so the read qualifier is not decoded.
  wire wr_ctl     = i_acc.wr && sel_ctl;
  wire wr_active  = i_acc.wr && sel_active;
  wire wr_second  = i_acc.wr && sel_second;
  wire wr_third   = i_acc.wr && sel_third;

  // Vectoring wins over a return in the same cycle; with paging off both are ignored.
  wire do_push    = i_irq.vector && auto_en;
  wire do_pop     = i_irq.ret && !i_irq.vector && auto_en;

  // Source to page table; unlisted sources use the default page.
  function automatic logic [7:0] src_page(input logic [rps_pkg::SRC_W-1:0] src);
    logic [7:0] pg;
    pg = rps_pkg::PAGE_DEFAULT;
    unique case (src)
      5'h0b:   pg = rps_pkg::PAGE_ALT_A;
      5'h0c,
      5'h0d,
      5'h0e,
      5'h10:   pg = rps_pkg::PAGE_ALT_B;
      default: pg = rps_pkg::PAGE_DEFAULT;
    endcase
    return pg;
  endfunction

  wire [7:0] entry_page = src_page(i_irq.src);

  // Push image: every entry moves one place down and the oldest page falls off the bottom.
  always_comb
  begin
    push_stack[0] = entry_page;
    for (int i = 1; i < DEPTH; i++)
    begin
      push_stack[i] = stack[i-1];
    end
  end

  // Pop image: the bottom entry is kept, since nothing lies below it to refill it.
  always_comb
  begin
    for (int i = 0; i < DEPTH - 1; i++)
    begin
      pop_stack[i] = stack[i+1];
    end
    pop_stack[DEPTH-1] = stack[DEPTH-1];
  end

  // Pick the image for this cycle's interrupt event, or hold the stack as it is.
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      if (do_push)
      begin
        event_stack[i] = push_stack[i];
      end
      else if (do_pop)
      begin
        event_stack[i] = pop_stack[i];
      end
      else
      begin
        event_stack[i] = stack[i];
      end
    end
  end

  // A write in the same cycle as an event lands after the move, so software has the last word on its entry.
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      next_stack[i] = event_stack[i];
    end
    if (wr_active)
    begin
      next_stack[0] = i_acc.wdata;
    end
    if (wr_second)
    begin
      next_stack[1] = i_acc.wdata;
    end
    if (wr_third)
    begin
      next_stack[2] = i_acc.wdata;
    end
  end

  // Only bit 0 of the control register is stored; the upper bits read as zero.
  always_comb
  begin
    next_auto_en = auto_en;
    if (wr_ctl)
    begin
      next_auto_en = i_acc.wdata[rps_pkg::CTL_EN_BIT];
    end
  end

  // Reset image of the stack; any deeper entries share the third entry's reset value.
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      rst_stack[i] = rps_pkg::RST_THIRD;
    end
    rst_stack[0] = rps_pkg::RST_ACTIVE;
    rst_stack[1] = rps_pkg::RST_SECOND;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        stack[i] <= rst_stack[i];
      end
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        stack[i] <= next_stack[i];
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      auto_en <= rps_pkg::RST_AUTO_EN;
    end
    else
    begin
      auto_en <= next_auto_en;
    end
  end

  // The active page leaves straight from its flip-flops, so the page never glitches during an access.
  assign o_page = stack[0];

  // Read path: one named word per register, masked by its select and merged.
  // The selects are mutually exclusive, so the merge needs no priority.
  wire [7:0] rd_ctl      = {7'h00, auto_en};
  wire [7:0] rd_active   = stack[0];
  wire [7:0] rd_second   = stack[1];
  wire [7:0] rd_third    = stack[2];
  wire [7:0] rd_ctl_m    = {8{sel_ctl}} & rd_ctl;
  wire [7:0] rd_active_m = {8{sel_active}} & rd_active;
  wire [7:0] rd_second_m = {8{sel_second}} & rd_second;
  wire [7:0] rd_third_m  = {8{sel_third}} & rd_third;
  wire [7:0] rd_mux      = rd_ctl_m | rd_active_m | rd_second_m | rd_third_m;

  // Addresses outside this block read as zero and do not claim the access.
  assign o_hit   = sel_any;
  assign o_rdata = rd_mux;

endmodule

// *** rps_core_model.sv ***
// Core-side model: issues one-cycle accesses and interrupt events from a packed row.
// Row: wr, addr, wdata, vector, src, ret in nibble-aligned fields.
`timescale 1ns/1ps
module rps_core_model (
  input  wire logic        i_core_clk, // Clock.
  output rps_pkg::rps_acc_t o_acc,     // Access.
  output rps_pkg::rps_irq_t o_irq      // Events.
);
  initial o_acc = '0;
  initial o_irq = '0;
  task automatic op(input logic [55:0] x);
    @(negedge i_core_clk);
    o_acc = '{x[52], 1'b1, x[51:44], x[43:36]};
    o_irq = '{x[32], x[28:24], x[16]};
    @(negedge i_core_clk);
    // Released data is scrambled so a stale latch cannot look right.
    o_acc = '{1'b0, 1'b1, x[51:44], ~x[43:36]};
    o_irq = '0;
  endtask
endmodule

// *** rps_page_stack_asserts.sv ***
// Checker on the page stack ports, bound to every instance below.
`timescale 1ns/1ps
module rps_page_stack_asserts (
  input wire logic              i_core_clk, // Clock.
  input wire logic              i_rst_n,    // Reset.
  input wire rps_pkg::rps_acc_t i_acc,      // Access.
  input wire rps_pkg::rps_irq_t i_irq,      // Events.
  input wire logic [7:0]        o_rdata,    // Read data.
  input wire logic              o_hit,      // Decode.
  input wire logic [7:0]        o_page      // Page.
);
  logic en;
  wire w7 = i_acc.wr && i_acc.addr == 8'ha7;
  wire ev = en && (i_irq.vector || i_irq.ret);
  always_ff @(posedge i_core_clk)
    en <= !i_rst_n ? 1'b1 : (i_acc.wr && i_acc.addr == 8'h84 ? i_acc.wdata[0] : en);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  property p_wr; w7 |=> o_page == $past(i_acc.wdata); endproperty
  a_wr: assert property (p_wr) else $error("page write lost");
  property p_hold; !w7 && !ev |=> $stable(o_page); endproperty
  a_hold: assert property (p_hold) else $error("page moved");
  property p_push; ev && i_irq.vector && i_irq.src == 5'h0b && !w7 |=> o_page == 8'h0c; endproperty
  a_push: assert property (p_push) else $error("bad entry page");
  property p_ctl; i_acc.addr == 8'h84 |-> o_hit && o_rdata == {7'h00, en}; endproperty
  a_ctl: assert property (p_ctl) else $error("bad control read");
  property p_rd; i_acc.addr == 8'ha7 |-> o_hit && o_rdata == o_page; endproperty
  a_rd: assert property (p_rd) else $error("active page read differs from page in use");
  property p_miss; !(i_acc.addr inside {8'h84, 8'h85, 8'ha6, 8'ha7}) |-> !o_hit && o_rdata == 8'h00; endproperty
  a_miss: assert property (p_miss) else $error("foreign address claimed");
  cover property (ev && i_irq.vector);
  cover property (ev && i_irq.ret);
  cover property (!en && i_irq.vector);
endmodule
bind rps_page_stack rps_page_stack_asserts chk_u (.i_core_clk, .i_rst_n, .i_acc, .i_irq, .o_rdata, .o_hit, .o_page);

// *** register_page_stack_tb.sv ***
// Bench: table of accesses and events with expected page and read data, then reset.
`timescale 1ns/1ps
module register_page_stack_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  rps_pkg::rps_acc_t acc;
  rps_pkg::rps_irq_t irq;
  logic [7:0] rdata, page;
  logic hit;
  logic [7:0] row_addr;
  int n_errors = 0, num_checks = 0, cyc = 0;
  logic [55:0] rows [15] = '{56'h1a733000003333, 56'h18544000003344, 56'h1a655000003355,
    56'h0a60010b000c44, 56'h0850010c00100c, 56'h08500000010c33, 56'h18577000000c77, 56'h0a600000017733,
    56'h08500101000077, 56'h18400000000000, 56'h0840010b000000, 56'h08500000010077, 56'h184ff000000001,
    56'h15099000000000, 56'h08500110001000};
  rps_core_model core_u (.i_core_clk(clk), .o_acc(acc), .o_irq(irq));
  rps_page_stack dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_acc(acc), .i_irq(irq), .o_rdata(rdata),
    .o_hit(hit), .o_page(page));
  task automatic test_done;
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 300)
    begin
      n_errors++;
      test_done;
    end
  end
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i])
    begin
      core_u.op(rows[i]);
      chk(page, rows[i][15:8]);
      chk(rdata, rows[i][7:0]);
      row_addr = rows[i][51:44];
      chk({7'h00, hit}, {7'h00, row_addr inside {rps_pkg::OFS_CONTROL, rps_pkg::OFS_SECOND,
        rps_pkg::OFS_ACTIVE, rps_pkg::OFS_THIRD}});
    end
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    chk(page, 8'h00);
    core_u.op(56'h08400000000000);
    chk(rdata, 8'h01);
    chk({7'h00, hit}, 8'h01);
    test_done;
  end
endmodule
